// [rtc_pkg.sv]
`default_nettype none
package rtc_pkg;
  // ****************************************
  // clock and bus
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 16;
  localparam logic [15:0] ADDR_CTRL = 16'h1860;
  localparam logic [15:0] ADDR_PRE = 16'h1864;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'h1868;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h186C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // register layout
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h33;
  localparam logic [7:0] PRE_RST = 8'h40;
  localparam logic [7:0] CTRL_WMASK = 8'hF3;
  localparam logic [7:0] PRE_WMASK = 8'hCC;
  localparam int TAIL_BIT = 7;
  localparam int LPF_HI = 6;
  localparam int LPF_LO = 4;
  localparam int RSV_HI = 3;
  localparam int RSV_LO = 2;
  localparam int RAMP_HI = 1;
  localparam int RAMP_LO = 0;
  localparam int TMO_HI = 7;
  localparam int TMO_LO = 6;
  localparam int FORCE_BIT = 3;
  localparam int PCEN_BIT = 2;
  localparam int DONE_BIT = 1;
  localparam logic [2:0] LPF_RST = 3'h3;
  localparam logic [1:0] RAMP_RST = 2'h3;
  localparam logic [1:0] TMO_OFF = 2'h0;
  localparam logic [1:0] TMO_C1 = 2'h1;
  localparam logic [1:0] TMO_C2 = 2'h2;
  localparam int IRQ_W = 2;
  localparam int IRQ_TMO_BIT = 0;
  localparam int IRQ_TAIL_BIT = 1;
  // ****************************************
  // timing
  // ****************************************
  localparam int TMO_NS_1 = 800000;
  localparam int TMO_NS_2 = 1600000;
  localparam int TMO_NS_3 = 2400000;
  localparam int TMO_PC_NS_1 = 1304000;
  localparam int TMO_PC_NS_2 = 2104000;
  localparam int TMO_PC_NS_3 = 2904000;
  localparam int TMO_W = 20;
  localparam int RAMP_NS_0 = 300;
  localparam int RAMP_NS_1 = 3000;
  localparam int RAMP_NS_2 = 6000;
  localparam int RAMP_NS_3 = 9000;
  localparam int RAMP_W = 10;
  localparam logic [9:0] RAMP_CYC_0 = 10'(RAMP_NS_0 / CLK_PERIOD_NS);
  localparam logic [9:0] RAMP_CYC_1 = 10'(RAMP_NS_1 / CLK_PERIOD_NS);
  localparam logic [9:0] RAMP_CYC_2 = 10'(RAMP_NS_2 / CLK_PERIOD_NS);
  localparam logic [9:0] RAMP_CYC_3 = 10'(RAMP_NS_3 / CLK_PERIOD_NS);
  localparam logic [1:0] TAIL_BITS = 2'h2;
  // ****************************************
  // transmit sequence
  // ****************************************
  typedef enum logic [2:0] {
    RTC_IDLE = 3'h0,
    RTC_PRECHG = 3'h1,
    RTC_LOCK = 3'h2,
    RTC_RUN = 3'h3,
    RTC_TAIL = 3'h4,
    RTC_HALT = 3'h5
  } rtc_tx_state_e;
endpackage
`default_nettype wire

// [rtc_lock_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module rtc_lock_timer
  import rtc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic [TMO_W-1:0] limit_i,
  output logic expired_o
);
  // ****************************************
  // cycle counter, zero limit never expires
  // ****************************************
  logic [TMO_W-1:0] cnt_reg;
  logic [TMO_W-1:0] cnt_next;

  always_comb begin
    cnt_next = '0;
    if (run_i && !expired_o) begin
      cnt_next = cnt_reg + TMO_W'(1);
    end else if (run_i) begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign expired_o = run_i && (limit_i != '0) && (cnt_reg >= limit_i);

endmodule // rtc_lock_timer
`default_nettype wire

// [rtc_regs.sv]
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rtc_regs
  import rtc_pkg::*;
#(
  parameter int TMO_CYC_1 = TMO_NS_1 / CLK_PERIOD_NS,
  parameter int TMO_CYC_2 = TMO_NS_2 / CLK_PERIOD_NS,
  parameter int TMO_CYC_3 = TMO_NS_3 / CLK_PERIOD_NS,
  parameter int TMO_PC_CYC_1 = TMO_PC_NS_1 / CLK_PERIOD_NS,
  parameter int TMO_PC_CYC_2 = TMO_PC_NS_2 / CLK_PERIOD_NS,
  // pre-charge adds one fixed span to every nonzero code
  parameter int TMO_PC_CYC_3 = TMO_PC_CYC_2 + TMO_CYC_3 - TMO_CYC_2
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic radio_module_reset_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic tx_start_i,
  input wire logic pll_lock_i,
  input wire logic precharge_cmp_i,
  input wire logic datagram_end_i,
  input wire logic bit_tick_i,
  output logic tail_carrier_o,
  output logic [2:0] loop_filter_select_o,
  output logic [1:0] amp_ramp_select_o,
  output logic [RAMP_W-1:0] amp_ramp_cycles_o,
  output logic comp_power_o,
  output logic regulator_precharge_o,
  output logic tx_run_o,
  output logic radio_error_flag_o,
  output logic irq_o
);
  // ****************************************
  // bus slave
  // ****************************************
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] pre_reg, pre_next;
  logic [IRQ_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [7:0] wbyte_reg, wbyte_next;
  logic wlane_reg, wlane_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic done_reg;
  logic [RAMP_W-1:0] ramp_cyc_reg, ramp_cyc_next;
  logic do_write, do_read, stat_rd;
  logic [IRQ_W-1:0] ev_set;
  rtc_tx_state_e state_reg, state_next;
  logic [1:0] tail_cnt_reg, tail_cnt_next;
  logic [TMO_W-1:0] tmo_limit;
  logic tmo_expired, tmo_run;

  assign s_axi_awready_o = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_have_reg && !bvalid_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign do_write = aw_have_reg && w_have_reg;
  assign do_read = s_axi_arvalid_i && s_axi_arready_o;
  assign stat_rd = do_read && (s_axi_araddr_i == ADDR_IRQ_STAT);

  always_comb begin
    awaddr_next = awaddr_reg;
    wbyte_next = wbyte_reg;
    wlane_next = wlane_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    bvalid_next = bvalid_reg && !s_axi_bready_i;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready_i;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    ctrl_next = ctrl_reg;
    pre_next = pre_reg;
    mask_next = mask_reg;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      awaddr_next = s_axi_awaddr_i;
      aw_have_next = 1'b1;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      wbyte_next = s_axi_wdata_i[7:0];
      wlane_next = s_axi_wstrb_i[0];
      w_have_next = 1'b1;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      unique case (awaddr_reg)
        ADDR_CTRL: if (wlane_reg) begin
          // reserved bits 3..2 stay zero
          ctrl_next = wbyte_reg & CTRL_WMASK;
        end
        ADDR_PRE: if (wlane_reg) begin
          pre_next = (wbyte_reg & PRE_WMASK) | (pre_reg & ~PRE_WMASK);
        end
        ADDR_IRQ_MASK: if (wlane_reg) begin
          mask_next = wbyte_reg[IRQ_W-1:0];
        end
        ADDR_IRQ_STAT: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = '0;
      unique case (s_axi_araddr_i)
        ADDR_CTRL: rdata_next[7:0] = ctrl_reg;
        ADDR_PRE: begin
          rdata_next[7:0] = pre_reg;
          rdata_next[DONE_BIT] = done_reg;
        end
        ADDR_IRQ_STAT: rdata_next[IRQ_W-1:0] = stat_reg;
        ADDR_IRQ_MASK: rdata_next[IRQ_W-1:0] = mask_reg;
        default: rresp_next = RESP_SLVERR;
      endcase
    end
    // module reset wins over a write in the same cycle
    if (radio_module_reset_i) begin
      ctrl_next = CTRL_RST;
      pre_next = PRE_RST;
    end
  end

  // ****************************************
  // sticky events, read clears, set wins
  // ****************************************
  assign ev_set[IRQ_TMO_BIT] = (state_next == RTC_HALT) &&
                               (state_reg != RTC_HALT);
  assign ev_set[IRQ_TAIL_BIT] = (state_reg == RTC_TAIL) &&
                                (state_next == RTC_IDLE);
  always_comb begin
    stat_next = stat_rd ? ev_set : (stat_reg | ev_set);
  end
  assign irq_o = |(stat_reg & mask_reg);

  always_comb begin
    unique case (ctrl_reg[RAMP_HI:RAMP_LO])
      2'h0: ramp_cyc_next = RAMP_CYC_0;
      2'h1: ramp_cyc_next = RAMP_CYC_1;
      2'h2: ramp_cyc_next = RAMP_CYC_2;
      2'h3: ramp_cyc_next = RAMP_CYC_3;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      awaddr_reg <= '0;
      wbyte_reg <= '0;
      wlane_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      ctrl_reg <= CTRL_RST;
      pre_reg <= PRE_RST;
      mask_reg <= '0;
      stat_reg <= '0;
      done_reg <= 1'b0;
      ramp_cyc_reg <= RAMP_CYC_3;
    end else begin
      awaddr_reg <= awaddr_next;
      wbyte_reg <= wbyte_next;
      wlane_reg <= wlane_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
      pre_reg <= pre_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      done_reg <= precharge_cmp_i;
      ramp_cyc_reg <= ramp_cyc_next;
    end
  end

  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;

  // ****************************************
  // static and sequenced analog controls
  // ****************************************
  assign loop_filter_select_o = ctrl_reg[LPF_HI:LPF_LO];
  assign amp_ramp_select_o = ctrl_reg[RAMP_HI:RAMP_LO];
  assign amp_ramp_cycles_o = ramp_cyc_reg;
  // comparator is off between pre-charge phases, unless FORCE_BIT is set, to save power
  assign comp_power_o = pre_reg[FORCE_BIT] ||
                        (state_reg == RTC_PRECHG);
  assign regulator_precharge_o = (state_reg == RTC_PRECHG);

  // ****************************************
  // lock timeout
  // ****************************************
  always_comb begin
    tmo_limit = '0;
    if (pre_reg[PCEN_BIT]) begin
      unique case (pre_reg[TMO_HI:TMO_LO])
        TMO_OFF: tmo_limit = '0;
        TMO_C1: tmo_limit = TMO_W'(TMO_PC_CYC_1);
        TMO_C2: tmo_limit = TMO_W'(TMO_PC_CYC_2);
        default: tmo_limit = TMO_W'(TMO_PC_CYC_3);
      endcase
    end else begin
      unique case (pre_reg[TMO_HI:TMO_LO])
        TMO_OFF: tmo_limit = '0;
        TMO_C1: tmo_limit = TMO_W'(TMO_CYC_1);
        TMO_C2: tmo_limit = TMO_W'(TMO_CYC_2);
        default: tmo_limit = TMO_W'(TMO_CYC_3);
      endcase
    end
  end

  // window covers pre-charge and lock wait together
  assign tmo_run = (state_reg == RTC_PRECHG) ||
                   (state_reg == RTC_LOCK);

  rtc_lock_timer u_timer (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .run_i(tmo_run),
    .limit_i(tmo_limit),
    .expired_o(tmo_expired)
  );

  // ****************************************
  // transmit sequence
  // ****************************************
  always_comb begin
    state_next = state_reg;
    tail_cnt_next = tail_cnt_reg;
    unique case (state_reg)
      RTC_IDLE, RTC_HALT: if (tx_start_i) begin
        state_next = pre_reg[PCEN_BIT] ? RTC_PRECHG : RTC_LOCK;
      end
      RTC_PRECHG: begin
        if (tmo_expired) begin
          state_next = RTC_HALT;
        end else if (precharge_cmp_i) begin
          state_next = RTC_LOCK;
        end
      end
      RTC_LOCK: begin
        if (pll_lock_i) begin
          state_next = RTC_RUN;
        end else if (tmo_expired) begin
          state_next = RTC_HALT;
        end
      end
      RTC_RUN: if (datagram_end_i) begin
        tail_cnt_next = '0;
        state_next = ctrl_reg[TAIL_BIT] ? RTC_TAIL : RTC_IDLE;
      end
      RTC_TAIL: if (bit_tick_i) begin
        tail_cnt_next = tail_cnt_reg + 2'h1;
        if (tail_cnt_reg + 2'h1 == TAIL_BITS) begin
          state_next = RTC_IDLE;
        end
      end
      default: state_next = RTC_IDLE;
    endcase
    if (radio_module_reset_i) begin
      state_next = RTC_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= RTC_IDLE;
      tail_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      tail_cnt_reg <= tail_cnt_next;
    end
  end

  assign tail_carrier_o = (state_reg == RTC_TAIL);
  assign tx_run_o = (state_reg == RTC_RUN);
  assign radio_error_flag_o = (state_reg == RTC_HALT);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence seq_end_with_tail;
    (state_reg == RTC_RUN) && datagram_end_i && ctrl_reg[TAIL_BIT] &&
      !radio_module_reset_i;
  endsequence
  sequence seq_timeout_hit;
    tmo_run && tmo_expired && !pll_lock_i && !radio_module_reset_i;
  endsequence

  AST_TAIL: assert property (seq_end_with_tail |=> tail_carrier_o)
    else $error("tail not started after datagram");
  AST_NO_TAIL: assert property (
    (state_reg == RTC_RUN) && datagram_end_i && !ctrl_reg[TAIL_BIT] |=>
    !tail_carrier_o)
    else $error("tail sent while disabled");
  AST_TAIL_RST: assert property (radio_module_reset_i |=>
    !ctrl_reg[TAIL_BIT])
    else $error("tail enable not cleared");
  AST_LPF_RST: assert property (radio_module_reset_i |=>
    loop_filter_select_o == LPF_RST)
    else $error("loop filter reset value wrong");
  AST_RAMP: assert property (amp_ramp_select_o == 2'h1 |=>
    amp_ramp_cycles_o == RAMP_CYC_1 || $changed(amp_ramp_select_o))
    else $error("ramp time mismatch");
  AST_RAMP_RST: assert property (radio_module_reset_i |=>
    amp_ramp_select_o == RAMP_RST)
    else $error("ramp reset value wrong");
  AST_TMO_PC: assert property (pre_reg[PCEN_BIT] &&
    pre_reg[TMO_HI:TMO_LO] == TMO_C1 |->
    tmo_limit == TMO_W'(TMO_PC_CYC_1))
    else $error("pre-charge timeout limit wrong");
  AST_TMO_OFF: assert property (
    pre_reg[TMO_HI:TMO_LO] == TMO_OFF |-> !tmo_expired)
    else $error("disabled timeout expired");
  AST_HALT: assert property (seq_timeout_hit |=>
    radio_error_flag_o && stat_reg[IRQ_TMO_BIT])
    else $error("timeout did not halt");
  AST_FORCE: assert property (pre_reg[FORCE_BIT] |-> comp_power_o)
    else $error("forced comparator is off");
  AST_PRECHG: assert property (
    (state_reg == RTC_IDLE) && tx_start_i && !radio_module_reset_i |=>
    regulator_precharge_o == $past(pre_reg[PCEN_BIT]))
    else $error("pre-charge phase wrong");
  AST_DONE: assert property (
    do_read && s_axi_araddr_i == ADDR_PRE |=>
    s_axi_rdata_o[DONE_BIT] == $past(done_reg))
    else $error("done status not returned");
  AST_RSV: assert property (ctrl_reg[RSV_HI:RSV_LO] == 2'h0)
    else $error("reserved bits set");

endmodule // rtc_regs
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import rtc_pkg::*;
;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic radio_module_reset_i = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr_i = '0;
  logic [ADDR_W-1:0] s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0;
  logic [3:0] s_axi_wstrb_i = '0;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic tx_start_i = 1'b0;
  logic pll_lock_i = 1'b0;
  logic precharge_cmp_i = 1'b0;
  logic datagram_end_i = 1'b0;
  logic bit_tick_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic tail_carrier_o, comp_power_o, regulator_precharge_o;
  logic tx_run_o, radio_error_flag_o, irq_o;
  logic [2:0] loop_filter_select_o;
  logic [1:0] amp_ramp_select_o;
  logic [RAMP_W-1:0] amp_ramp_cycles_o;
  integer seed = 32'h9C00C70C;
  int err_count = 0;
  int comparisons = 0;
  localparam int P_START = 0;
  localparam int P_END = 1;
  localparam int P_TICK = 2;
  localparam int P_RST = 3;

  // short limits keep the run small; expectations derive from them
  // code 3 with pre-charge follows from the others, giving 70
  rtc_regs #(.TMO_CYC_1(20), .TMO_CYC_2(40), .TMO_CYC_3(60),
    .TMO_PC_CYC_1(30), .TMO_PC_CYC_2(50)) dut_u (
    .core_clk_i, .rstn_i, .radio_module_reset_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .tx_start_i, .pll_lock_i, .precharge_cmp_i, .datagram_end_i,
    .bit_tick_i, .tail_carrier_o, .loop_filter_select_o,
    .amp_ramp_select_o, .amp_ramp_cycles_o, .comp_power_o,
    .regulator_precharge_o, .tx_run_o, .radio_error_flag_o, .irq_o);

  initial begin
    forever #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
  end

  // ****************************************
  // expectations and helpers
  // ****************************************
  function automatic int lim(logic [1:0] c, logic pc);
    lim = 20 * int'(c) + (pc ? 10 : 0);
  endfunction

  function automatic logic [9:0] ramp_exp(logic [1:0] c);
    case (c)
      2'h0: ramp_exp = 10'(RAMP_NS_0 / CLK_PERIOD_NS);
      2'h1: ramp_exp = 10'(RAMP_NS_1 / CLK_PERIOD_NS);
      2'h2: ramp_exp = 10'(RAMP_NS_2 / CLK_PERIOD_NS);
      default: ramp_exp = 10'(RAMP_NS_3 / CLK_PERIOD_NS);
    endcase
  endfunction

  function automatic logic sig(int sel);
    case (sel)
      0: sig = tx_run_o;
      1: sig = radio_error_flag_o;
      default: sig = tail_carrier_o;
    endcase
  endfunction

  task automatic results;
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic hang(input string nm);
    $display("MISMATCH %s expected response seen timeout", nm);
    err_count++;
    results();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // one-cycle strobe; selector since a ref cannot take a non-blocking write
  task automatic pulse(input int sel);
    @(posedge core_clk_i);
    case (sel)
      P_START: tx_start_i <= 1'b1;
      P_END: datagram_end_i <= 1'b1;
      P_TICK: bit_tick_i <= 1'b1;
      default: radio_module_reset_i <= 1'b1;
    endcase
    @(posedge core_clk_i);
    tx_start_i <= 1'b0;
    datagram_end_i <= 1'b0;
    bit_tick_i <= 1'b0;
    radio_module_reset_i <= 1'b0;
  endtask

  task automatic wait_hi(input int sel, input int n);
    int k;
    k = 0;
    while (sig(sel) !== 1'b1) begin
      @(posedge core_clk_i);
      if (++k > n) hang("state output");
    end
  endtask

  // ****************************************
  // register bus master
  // ****************************************
  task automatic axi_wr(input logic [15:0] a, input logic [7:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    bit aw, w;
    int n;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= {24'($random(seed)), d};
    s_axi_wstrb_i <= s;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    aw = 0;
    w = 0;
    n = 0;
    while (!(aw && w)) begin
      @(posedge core_clk_i);
      if (!aw && s_axi_awready_o === 1'b1) begin
        aw = 1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (!w && s_axi_wready_o === 1'b1) begin
        w = 1;
        s_axi_wvalid_i <= 1'b0;
      end
      if (++n > 50) hang("write accept");
    end
    n = 0;
    do begin
      @(posedge core_clk_i);
      if (++n > 50) hang("bvalid");
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp_o));
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e,
                        input logic [1:0] er);
    int n;
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      if (++n > 50) hang("arready");
    end while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk_i);
      if (++n > 50) hang("rvalid");
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    chk("rdata", {24'h0, e}, s_axi_rdata_o);
    chk("rresp", 32'(er), 32'(s_axi_rresp_o));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    chk("lpf out", 32'(LPF_RST), 32'(loop_filter_select_o));
    chk("ramp out", 32'(RAMP_RST), 32'(amp_ramp_select_o));
    chk("ramp cyc", 32'(ramp_exp(2'h3)), 32'(amp_ramp_cycles_o));
    rd_chk(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    rd_chk(ADDR_PRE, PRE_RST, RESP_OKAY);
    // random control words, first four sweep every ramp code
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      if (i < 4) d[1:0] = 2'(i);
      axi_wr(ADDR_CTRL, d, 4'h1, RESP_OKAY);
      rd_chk(ADDR_CTRL, d & CTRL_WMASK, RESP_OKAY);
      chk("lpf out", 32'(d[6:4]), 32'(loop_filter_select_o));
      chk("ramp out", 32'(d[1:0]), 32'(amp_ramp_select_o));
      chk("ramp cyc", 32'(ramp_exp(d[1:0])), 32'(amp_ramp_cycles_o));
    end
    axi_wr(ADDR_CTRL, ~d, 4'h0, RESP_OKAY);
    rd_chk(ADDR_CTRL, d & CTRL_WMASK, RESP_OKAY);
    axi_wr(16'h1870, 8'hFF, 4'h1, RESP_SLVERR);
    rd_chk(16'h1870, 8'h00, RESP_SLVERR);
    pulse(P_RST);
    rd_chk(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    // precharge register with the comparator level varied
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      precharge_cmp_i <= d[0];
      axi_wr(ADDR_PRE, d, 4'h1, RESP_OKAY);
      rd_chk(ADDR_PRE, (d & PRE_WMASK) | {6'h0, d[0], 1'b0}, RESP_OKAY);
      chk("comp power", 32'(d[FORCE_BIT]), 32'(comp_power_o));
      chk("precharge", 32'h0, 32'(regulator_precharge_o));
    end
    precharge_cmp_i <= 1'b0;
    pulse(P_RST);
    rd_chk(ADDR_PRE, PRE_RST, RESP_OKAY);
    // full transfer with precharge and tail
    axi_wr(ADDR_IRQ_MASK, 8'h01, 4'h1, RESP_OKAY);
    axi_wr(ADDR_CTRL, 8'hB3, 4'h1, RESP_OKAY);
    axi_wr(ADDR_PRE, 8'h04, 4'h1, RESP_OKAY);
    pulse(P_START);
    cyc(1);
    chk("precharge", 32'h1, 32'(regulator_precharge_o));
    chk("comp power", 32'h1, 32'(comp_power_o));
    precharge_cmp_i <= 1'b1;
    cyc(2);
    chk("precharge", 32'h0, 32'(regulator_precharge_o));
    precharge_cmp_i <= 1'b0;
    pll_lock_i <= 1'b1;
    wait_hi(0, 5);
    pulse(P_END);
    wait_hi(2, 5);
    pulse(P_TICK);
    cyc(1);
    chk("tail", 32'h1, 32'(tail_carrier_o));
    pulse(P_TICK);
    cyc(1);
    chk("tail", 32'h0, 32'(tail_carrier_o));
    cyc(2);
    chk("irq", 32'h0, 32'(irq_o));
    rd_chk(ADDR_IRQ_STAT, 8'h02, RESP_OKAY);
    rd_chk(ADDR_IRQ_STAT, 8'h00, RESP_OKAY);
    // tail disabled: nothing appended
    axi_wr(ADDR_CTRL, 8'h33, 4'h1, RESP_OKAY);
    axi_wr(ADDR_PRE, 8'h00, 4'h1, RESP_OKAY);
    pulse(P_START);
    wait_hi(0, 10);
    pulse(P_END);
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      chk("tail", 32'h0, 32'(tail_carrier_o));
    end
    chk("run", 32'h0, 32'(tx_run_o));
    pll_lock_i <= 1'b0;
    // lock timeout for every code, precharge off and on
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        axi_wr(ADDR_PRE, {2'(c), 3'h0, 1'(p), 2'h0}, 4'h1, RESP_OKAY);
        pulse(P_START);
        if (c == 0) begin
          cyc(100);
          chk("error", 32'h0, 32'(radio_error_flag_o));
        end else begin
          cyc(lim(2'(c), 1'(p)) - 4);
          chk("error", 32'h0, 32'(radio_error_flag_o));
          chk("precharge", 32'(p), 32'(regulator_precharge_o));
          wait_hi(1, 10);
          cyc(2);
          chk("irq", 32'h1, 32'(irq_o));
          rd_chk(ADDR_IRQ_STAT, 8'h01, RESP_OKAY);
          chk("irq", 32'h0, 32'(irq_o));
        end
        pulse(P_RST);
        cyc(1);
        chk("error", 32'h0, 32'(radio_error_flag_o));
      end
    end
    // software status check: force on, read, force off
    precharge_cmp_i <= 1'b1;
    axi_wr(ADDR_PRE, PRE_RST | 8'h08, 4'h1, RESP_OKAY);
    chk("comp power", 32'h1, 32'(comp_power_o));
    rd_chk(ADDR_PRE, PRE_RST | 8'h0A, RESP_OKAY);
    axi_wr(ADDR_PRE, PRE_RST, 4'h1, RESP_OKAY);
    chk("comp power", 32'h0, 32'(comp_power_o));
    precharge_cmp_i <= 1'b0;
    results();
  end
endmodule // tb_top
`default_nettype wire
